// file: rtl/hbm_map.svh
// Address map, field positions and counts of the host buffer memory.
// Assumes a 16-bit processor byte address and a 64-bit internal word.
`ifndef HBM_MAP_SVH
`define HBM_MAP_SVH

// ----------------------------------------
// Space sizes in kilobytes
// ----------------------------------------
`define HBM_TOTAL_KB    64
`define HBM_REG_KB      1
`define HBM_BUF_KB      63
`define HBM_PAY_KB      60

// ----------------------------------------
// Region bases and limits (byte addresses)
// ----------------------------------------
`define HBM_BUF_BASE    16'h0400
`define HBM_ISO_BASE    16'h0400
`define HBM_INT_BASE    16'h0800
`define HBM_ASY_BASE    16'h0C00
`define HBM_DESC_LAST   16'h0FFF
`define HBM_PAY_BASE    16'h1000
`define HBM_PAY_LAST    16'hFFFF

// ----------------------------------------
// Address fields and counts
// ----------------------------------------
`define HBM_WORD_SHIFT  3
`define HBM_TD_IDX_MSB  9
`define HBM_TD_IDX_LSB  5
`define HBM_TD_DWORD_MSB 4
`define HBM_TD_DWORD_LSB 2
`define HBM_TD_MAX      32
`define HBM_TD_DWORDS   8
`define HBM_TYPES       3
`define HBM_PORTS       3
`define HBM_CLK_PORT    2'h2
`define HBM_PD_RESET    3'h7
`define HBM_ROUTE_HUB   3'h7
`define HBM_MEM_WORDS   ((`HBM_BUF_KB * 1024) >> `HBM_WORD_SHIFT)
`define HBM_MADDR_W     13

`endif

// file: rtl/hbm_pkg.sv
// Types shared by the host buffer memory design.
// Assumes hbm_map.svh is on the include path.
`default_nettype none
`include "hbm_map.svh"

package hbm_pkg;
	// Decoded region of a processor address
	typedef enum logic [2:0] {
		RG_REG   = 3'h0,
		RG_ISO   = 3'h1,
		RG_INT   = 3'h2,
		RG_ASY   = 3'h3,
		RG_PAY   = 3'h4
	} region_t;

	// Root hub port view of the internal hub, one-hot
	typedef enum logic [2:0] {
		HUB_DETACHED   = 3'h1,
		HUB_ATTACHED   = 3'h2,
		HUB_ENUMERATED = 3'h4
	} hub_state_t;

	typedef logic [`HBM_MADDR_W-1:0] maddr_t;
	typedef logic [1:0]              td_type_t;
	typedef logic [4:0]              td_index_t;
endpackage

`default_nettype wire

// file: rtl/mem_port_if.sv
// One requester port of the shared buffer memory.
// Assumes one clock; gnt is combinational from the arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "hbm_map.svh"

interface mem_port_if;
	logic                    req;    // Access wanted this cycle
	logic                    we;     // Write when high
	logic [`HBM_MADDR_W-1:0] addr;   // 64-bit word index
	logic [63:0]             wdata;  // Write data
	logic [7:0]              be;     // Byte enables
	logic                    gnt;    // Access taken this cycle

	modport client (output req, we, addr, wdata, be, input gnt);
	modport arb    (input req, we, addr, wdata, be, output gnt);
endinterface

`default_nettype wire

// file: rtl/buffer_arbiter.sv
// Two-way arbiter for the single-ported 64-bit buffer memory.
// Assumes both clients present req with stable fields until gnt.
`timescale 1ns/1ps
`default_nettype none

module buffer_arbiter
(
	input  wire logic           mclk_i,       // System clock
	input  wire logic           reset_i,      // Sync reset, high
	mem_port_if.arb             cpu_p,        // Processor port
	mem_port_if.arb             eng_p,        // Host engine port
	output logic                mem_en_o,     // Memory cycle
	output logic                mem_we_o,     // Memory write
	output hbm_pkg::maddr_t     mem_addr_o,   // Word index
	output logic [63:0]         mem_wdata_o,  // Write data
	output logic [7:0]          mem_be_o,     // Byte enables
	output logic                mem_eng_o     // Cycle belongs to engine
);
	import hbm_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic eng_prio;  // Engine wins the next tie
	} arb_state_t;

	arb_state_t cur_ff;   // Registered state
	arb_state_t nxt_cur;  // Next state

	// Winner picked by alternating priority so neither side starves
	always_comb
	begin
		nxt_cur   = cur_ff;
		eng_p.gnt = eng_p.req && (!cpu_p.req || cur_ff.eng_prio);
		cpu_p.gnt = cpu_p.req && !eng_p.gnt;
		if (eng_p.gnt && cpu_p.req)
			nxt_cur.eng_prio = 1'b0;
		else if (cpu_p.gnt && eng_p.req)
			nxt_cur.eng_prio = 1'b1;
		mem_eng_o   = eng_p.gnt;
		mem_en_o    = eng_p.gnt || cpu_p.gnt;
		mem_we_o    = eng_p.gnt ? eng_p.we : cpu_p.we;
		mem_addr_o  = eng_p.gnt ? eng_p.addr : cpu_p.addr;
		mem_wdata_o = eng_p.gnt ? eng_p.wdata : cpu_p.wdata;
		mem_be_o    = eng_p.gnt ? eng_p.be : cpu_p.be;
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_single_grant: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(cpu_p.gnt && eng_p.gnt) && (mem_en_o == (cpu_p.req || eng_p.req)))
		else $error("grant not exclusive or memory left idle");
endmodule // buffer_arbiter

`default_nettype wire

// file: rtl/host_buffer_memory_map.sv
// Buffer memory, address map, completion flags and hub wiring of a slave host.
// Assumes processor and host engine run on mclk_i; requests hold until taken.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - External ports always routed to internal hub
// - Host clock taken from port two
// - Port two clock runs without enable
// - Line pull-downs enabled after reset
// - 64 kB space, 1 kB registers
// - Descriptors occupy 0400h to 0FFFh
// - Payload occupies 1000h to FFFFh
// - Three descriptor areas, one per type
// - Up to 32 descriptors per type
// - Descriptor is eight double words
// - Completion flags interrupt through OR/AND masks
// - Processor and engine alternate on ties, so the engine waits at most one cycle
// - Buffer accesses are double-word aligned
// - Internal address is (addr - 0400h) >> 3
// - Internal hub reports three ports
// - Arbiter shares 64-bit memory path
module host_buffer_memory_map
(
	input  wire logic            mclk_i,          // 50 MHz clock
	input  wire logic            reset_i,         // Sync reset, high
	input  wire logic            cpu_req_i,       // Processor access
	input  wire logic            cpu_we_i,        // Processor write
	input  wire logic [15:0]     cpu_addr_i,      // Byte address
	input  wire logic [31:0]     cpu_wdata_i,     // Write data
	output logic                 cpu_ready_o,     // Access taken
	output logic                 cpu_rvalid_o,    // Read data valid pulse
	output logic [31:0]          cpu_rdata_o,     // Read data
	output logic                 cpu_reg_sel_o,   // Register access taken
	output logic                 cpu_align_err_o, // Unaligned buffer access
	output hbm_pkg::region_t     cpu_region_o,    // Decoded region
	output hbm_pkg::td_index_t   cpu_td_index_o,  // Descriptor slot
	output logic [2:0]           cpu_td_dword_o,  // Double word in slot
	input  wire logic            eng_req_i,       // Engine access
	input  wire logic            eng_we_i,        // Engine write
	input  wire hbm_pkg::maddr_t eng_addr_i,      // Engine word index
	input  wire logic [63:0]     eng_wdata_i,     // Engine write data
	output logic                 eng_gnt_o,       // Engine access taken
	output logic                 eng_rvalid_o,    // Engine read valid
	output logic [63:0]          eng_rdata_o,     // Engine read data
	input  wire logic            eng_done_i,      // Descriptor finished
	input  wire hbm_pkg::td_type_t  eng_done_type_i, // Its list type
	input  wire hbm_pkg::td_index_t eng_done_idx_i,  // Its slot
	input  wire logic            done_clr_i,      // Clear one flag
	input  wire hbm_pkg::td_type_t  done_clr_type_i, // Flag list type
	input  wire hbm_pkg::td_index_t done_clr_idx_i,  // Flag slot
	input  wire logic [2:0]      irq_or_mask_i,   // Any-of type mask
	input  wire logic [2:0]      irq_and_mask_i,  // All-of type mask
	output logic [95:0]          done_o,          // Completion flags
	output logic                 irq_o,           // Interrupt, high
	input  wire logic            pd_off_i,        // Drop pull-downs
	input  wire logic            hub_enum_done_i, // Hub enumerated
	output logic [2:0]           pulldown_en_o,   // Line pull-downs
	output logic [2:0]           route_hub_o,     // Port to hub routing
	output logic [1:0]           clk_src_port_o,  // Clock source port
	output logic                 port2_clk_en_o,  // Port 2 clock on
	output logic                 root_conn_o,     // Root port connect
	output logic [1:0]           hub_ports_o      // Hub port count
);
	import hbm_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Processor byte address to 64-bit word index
	function automatic maddr_t to_index(input logic [15:0] a);
		logic [15:0] d;
		d = {a[15:2], 2'h0} - `HBM_BUF_BASE;
		return d[15:`HBM_WORD_SHIFT];
	endfunction

	// Region of a processor byte address
	function automatic region_t to_region(input logic [15:0] a);
		if (a < `HBM_BUF_BASE)
			return RG_REG;
		else if (a < `HBM_INT_BASE)
			return RG_ISO;
		else if (a < `HBM_ASY_BASE)
			return RG_INT;
		else if (a <= `HBM_DESC_LAST)
			return RG_ASY;
		else
			return RG_PAY;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		hub_state_t  hub;       // Root port view
		logic [2:0]  pd_en;     // Pull-down enables
		logic [95:0] done;      // Completion flags
		logic        cpu_rd;    // Processor read in flight
		logic        cpu_hi;    // Upper half selected
		logic        eng_rd;    // Engine read in flight
		logic        reg_sel;   // Register access pulse
		logic        align_err; // Unaligned access pulse
	} top_state_t;

	top_state_t cur_ff;   // Registered state
	top_state_t nxt_cur;  // Next state

	logic [63:0] mem_ff [`HBM_MEM_WORDS];  // Buffer array, 63 kB
	logic [63:0] mem_q_ff;                 // Read data register

	mem_port_if cpu_p ();  // Processor memory port
	mem_port_if eng_p ();  // Engine memory port

	logic            mem_en;     // Memory cycle
	logic            mem_we;     // Memory write
	maddr_t          mem_addr;   // Word index
	logic [63:0]     mem_wdata;  // Write data
	logic [7:0]      mem_be;     // Byte enables
	logic            mem_eng;    // Cycle is engine's
	region_t         cpu_rg;     // Region of request
	logic            cpu_buf;    // Request targets buffer

	// ----------------------------------------
	// Address decode and client ports
	// ----------------------------------------
	// Register space never reaches the array
	always_comb
	begin
		cpu_rg      = to_region(cpu_addr_i);
		cpu_buf     = cpu_req_i && (cpu_rg != RG_REG);
		cpu_p.req   = cpu_buf;
		cpu_p.we    = cpu_we_i;
		cpu_p.addr  = to_index(cpu_addr_i);
		cpu_p.wdata = {cpu_wdata_i, cpu_wdata_i};
		// Double word lands in its half of the 64-bit word
		cpu_p.be    = cpu_addr_i[2] ? 8'hF0 : 8'h0F;
		eng_p.req   = eng_req_i;
		eng_p.we    = eng_we_i;
		eng_p.addr  = eng_addr_i;
		eng_p.wdata = eng_wdata_i;
		eng_p.be    = 8'hFF;
	end

	// Shared memory arbiter
	buffer_arbiter u_arb
	(
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.cpu_p       (cpu_p),
		.eng_p       (eng_p),
		.mem_en_o    (mem_en),
		.mem_we_o    (mem_we),
		.mem_addr_o  (mem_addr),
		.mem_wdata_o (mem_wdata),
		.mem_be_o    (mem_be),
		.mem_eng_o   (mem_eng)
	);

	// ----------------------------------------
	// Buffer array
	// ----------------------------------------
	// Byte-lane writes keep the other half intact
	always_ff @(posedge mclk_i)
	begin
		if (mem_en && mem_we)
		begin
			for (int b = 0; b < 8; b++)
				if (mem_be[b])
					mem_ff[mem_addr][b*8 +: 8] <= mem_wdata[b*8 +: 8];
		end
		if (mem_en && !mem_we)
			mem_q_ff <= mem_ff[mem_addr];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_cur           = cur_ff;
		nxt_cur.cpu_rd    = cpu_p.gnt && !cpu_we_i;
		nxt_cur.cpu_hi    = cpu_p.gnt ? cpu_addr_i[2] : cur_ff.cpu_hi;
		nxt_cur.eng_rd    = eng_p.gnt && !eng_we_i;
		nxt_cur.reg_sel   = cpu_req_i && (cpu_rg == RG_REG);
		nxt_cur.align_err = cpu_buf && (cpu_addr_i[1:0] != 2'h0);
		// Pull-downs stay on until told otherwise
		if (pd_off_i)
			nxt_cur.pd_en = 3'h0;
		// Clear first so a same-cycle completion wins
		if (done_clr_i && (done_clr_type_i < 2'h3))
			nxt_cur.done[{done_clr_type_i, done_clr_idx_i}] = 1'b0;
		if (eng_done_i && (eng_done_type_i < 2'h3))
			nxt_cur.done[{eng_done_type_i, eng_done_idx_i}] = 1'b1;
		// Internal hub appears once and never leaves
		unique case (cur_ff.hub)
			HUB_DETACHED:
				nxt_cur.hub = HUB_ATTACHED;
			HUB_ATTACHED:
				if (hub_enum_done_i)
					nxt_cur.hub = HUB_ENUMERATED;
			HUB_ENUMERATED:
				nxt_cur.hub = HUB_ENUMERATED;
			default:
				nxt_cur.hub = HUB_DETACHED;
		endcase
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			cur_ff       <= '0;
			cur_ff.hub   <= HUB_DETACHED;
			cur_ff.pd_en <= `HBM_PD_RESET;
		end
		else
			cur_ff <= nxt_cur;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic [2:0] type_any;  // Some flag of each type set

	always_comb
	begin
		for (int t = 0; t < `HBM_TYPES; t++)
			type_any[t] = |cur_ff.done[t*`HBM_TD_MAX +: `HBM_TD_MAX];
		irq_o = |(type_any & irq_or_mask_i) ||
			((|irq_and_mask_i) && ((type_any & irq_and_mask_i) == irq_and_mask_i));
	end

	assign cpu_ready_o     = cpu_p.gnt || cur_ff.reg_sel;
	assign cpu_rvalid_o    = cur_ff.cpu_rd;
	assign cpu_rdata_o     = cur_ff.cpu_hi ? mem_q_ff[63:32] : mem_q_ff[31:0];
	assign cpu_reg_sel_o   = cur_ff.reg_sel;
	assign cpu_align_err_o = cur_ff.align_err;
	assign cpu_region_o    = cpu_rg;
	assign cpu_td_index_o  = cpu_addr_i[`HBM_TD_IDX_MSB:`HBM_TD_IDX_LSB];
	assign cpu_td_dword_o  = cpu_addr_i[`HBM_TD_DWORD_MSB:`HBM_TD_DWORD_LSB];
	assign eng_gnt_o       = eng_p.gnt;
	assign eng_rvalid_o    = cur_ff.eng_rd;
	assign eng_rdata_o     = mem_q_ff;
	assign done_o          = cur_ff.done;
	assign pulldown_en_o   = cur_ff.pd_en;
	assign route_hub_o     = `HBM_ROUTE_HUB;
	assign clk_src_port_o  = `HBM_CLK_PORT;
	assign port2_clk_en_o  = 1'b1;
	assign root_conn_o     = cur_ff.hub != HUB_DETACHED;
	assign hub_ports_o     = 2'h3;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	sequence s_done_or;
		eng_done_i && (eng_done_type_i < 2'h3) && irq_or_mask_i[eng_done_type_i] && !done_clr_i;
	endsequence

	sequence s_cpu_wait;
		cpu_p.req && !cpu_p.gnt ##1 cpu_p.req;
	endsequence

	a_hub_routing: assert property (route_hub_o == 3'h7 && hub_ports_o == 2'h3)
		else $error("ports not all routed to hub");
	a_clock_source: assert property (clk_src_port_o == 2'h2 && port2_clk_en_o)
		else $error("host clock not from port 2");
	a_pd_reset: assert property ($past(reset_i) |-> pulldown_en_o == 3'h7)
		else $error("pull-downs off after reset");
	a_reg_isolated: assert property (cpu_req_i && cpu_addr_i < 16'h0400 |-> !cpu_p.gnt ##1 cpu_reg_sel_o)
		else $error("register access reached memory");
	a_region_split: assert property (cpu_addr_i >= 16'h0800 && cpu_addr_i < 16'h0C00 |-> cpu_region_o == RG_INT)
		else $error("interrupt area misdecoded");
	a_payload_map: assert property (cpu_addr_i >= 16'h1000 |-> cpu_region_o == RG_PAY)
		else $error("payload area misdecoded");
	a_index_map: assert property (cpu_p.gnt |-> mem_addr == 13'((cpu_addr_i - 16'h0400) >> 3))
		else $error("internal index wrong");
	a_done_irq: assert property (s_done_or ##1 $stable(irq_or_mask_i) |-> irq_o && done_o != 96'h0)
		else $error("completion raised no interrupt");
	a_cpu_no_starve: assert property (s_cpu_wait |-> cpu_p.gnt)
		else $error("processor starved by engine");
	a_read_return: assert property (cpu_rvalid_o == $past(cpu_p.gnt && !cpu_we_i))
		else $error("read valid not one cycle after read grant");
	a_align_flag: assert property (cpu_buf && cpu_addr_i[1:0] != 2'h0 |=> cpu_align_err_o)
		else $error("unaligned access not flagged");

	a_hub_sticky: assert property (root_conn_o |=> root_conn_o)
		else $error("internal hub left the root port");
endmodule // host_buffer_memory_map

`default_nettype wire

// file: dv/cpu_bus_model.sv
// Processor partner model driving the parallel buffer port of the host block.
// Assumes one clock; requests are changed only at falling edges.
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model
(
	input  wire logic  mclk_i,   // System clock
	input  wire logic  ready_i,  // Access taken
	input  wire logic  conn_i,   // Root port connect seen
	output logic       req_o,    // Access request
	output logic       we_o,     // Write when high
	output logic [15:0] addr_o,  // Byte address
	output logic [31:0] wdata_o, // Write data
	output logic       enum_o    // Hub enumerated pulse
);
	// ----------------------------------------
	// Idle bus at time zero
	// ----------------------------------------
	initial
	begin
		req_o   = 1'h0;
		we_o    = 1'h0;
		addr_o  = 16'h0000;
		wdata_o = 32'h0000_0000;
		enum_o  = 1'h0;
	end

	// One access, held until the port takes it
	task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		req_o   = 1'h1;
		we_o    = w;
		addr_o  = a;     // Callers may hand unaligned and register addresses
		wdata_o = d;     // Data sent unmodified, as the caller gives it
		#1;
		while (ready_i !== 1'h1)
		begin
			@(negedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		// Drop request so a held one is not taken again
		@(negedge mclk_i);
		req_o   = 1'h0;
	endtask

	// Release; address and data lines no longer show the last value
	task automatic release_bus();
		@(negedge mclk_i);
		req_o   = 1'h0;
		addr_o  = ~addr_o;
		wdata_o = ~wdata_o;
	endtask

	// Poll root port, enumerate hub as an external one, then stop polling
	task automatic enumerate_hub();
		while (conn_i !== 1'h1)
			@(negedge mclk_i);   // Poll until connect
		@(negedge mclk_i);
		enum_o = 1'h1;           // Standard hub enumeration done
		@(negedge mclk_i);
		enum_o = 1'h0;           // No further polling
	endtask
endmodule // cpu_bus_model

`default_nettype wire

// file: dv/tb_host_buffer_memory_map.sv
// Self-checking bench of the host buffer memory map block.
// Assumes the design files and the processor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module tb_host_buffer_memory_map;
	import hbm_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        mclk_i, reset_i, cpu_req_i, cpu_we_i, cpu_ready_o, cpu_rvalid_o, cpu_reg_sel_o;
	logic        cpu_align_err_o, eng_req_i, eng_we_i, eng_gnt_o, eng_rvalid_o, eng_done_i, done_clr_i;
	logic        irq_o, pd_off_i, hub_enum_done_i, port2_clk_en_o, root_conn_o;
	logic [15:0] cpu_addr_i, seed, a;
	logic [31:0] cpu_wdata_i, cpu_rdata_o, c_exp;
	region_t     cpu_region_o;
	td_index_t   cpu_td_index_o, eng_done_idx_i, done_clr_idx_i;
	td_type_t    eng_done_type_i, done_clr_type_i;
	logic [2:0]  cpu_td_dword_o, irq_or_mask_i, irq_and_mask_i, pulldown_en_o, route_hub_o;
	maddr_t      eng_addr_i;
	logic [63:0] eng_wdata_i, eng_rdata_o, e_exp;
	logic [95:0] done_o, exp_done;
	logic [1:0]  clk_src_port_o, hub_ports_o;
	int          fail_count, samples_checked;
	logic [31:0] mem [int];           // Expected buffer content per dword
	logic [31:0] cpu_q [$];           // Expected processor read data
	logic [63:0] eng_q [$];           // Expected engine read data
	logic [15:0] addr_q [$];          // Random addresses written
	logic [15:0] dec_a [8] = '{16'h03FC, 16'h0400, 16'h07FC, 16'h0800, 16'h0BFC, 16'h0C00, 16'h0FFC, 16'h1000};
	region_t     dec_r [8] = '{RG_REG, RG_ISO, RG_ISO, RG_INT, RG_INT, RG_ASY, RG_ASY, RG_PAY};

	// Clock, 20 ns period
	initial
	begin
		mclk_i = 1'h0;
		forever #10 mclk_i = ~mclk_i;
	end

	host_buffer_memory_map i_dut (.*);
	cpu_bus_model i_cpu (.mclk_i(mclk_i), .ready_i(cpu_ready_o), .conn_i(root_conn_o), .req_o(cpu_req_i),
		.we_o(cpu_we_i), .addr_o(cpu_addr_i), .wdata_o(cpu_wdata_i), .enum_o(hub_enum_done_i));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic wr(input logic [15:0] ad, input logic [31:0] d);
		i_cpu.access(1'h1, ad, d);
		mem[ad[15:2]] = d;
	endtask

	task automatic rd(input logic [15:0] ad);
		cpu_q.push_back(mem[ad[15:2]]);
		i_cpu.access(1'h0, ad, 32'h0);
	endtask

	// Engine access; word ad holds dwords 100h+2ad and 100h+2ad+1
	task automatic eng_acc(input logic w, input maddr_t ad, input logic [63:0] d);
		int k;
		k = 16'h0100 + 2 * int'(ad);
		if (!w)
			eng_q.push_back({mem[k + 1], mem[k]});
		@(negedge mclk_i);
		{eng_req_i, eng_we_i, eng_addr_i, eng_wdata_i} = {1'h1, w, ad, d};
		#1;
		while (eng_gnt_o !== 1'h1)
		begin
			@(negedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		if (w)
		begin
			mem[k] = d[31:0];
			mem[k + 1] = d[63:32];
		end
		@(negedge mclk_i);
		{eng_req_i, eng_addr_i, eng_wdata_i} = {1'h0, ~ad, ~d};
	endtask

	// Completion set (s high) or clear pulse
	task automatic flag(input logic s, input td_type_t t, input td_index_t i);
		@(negedge mclk_i);
		if (s)
			{eng_done_i, eng_done_type_i, eng_done_idx_i} = {1'h1, t, i};
		else
			{done_clr_i, done_clr_type_i, done_clr_idx_i} = {1'h1, t, i};
		@(negedge mclk_i);
		{eng_done_i, done_clr_i} = 2'h0;
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Result monitor, oldest note first
	// ----------------------------------------
	always @(negedge mclk_i)
	begin
		if (cpu_rvalid_o === 1'h1)
		begin
			c_exp = cpu_q.pop_front();
			`CHK(cpu_rdata_o, c_exp)
		end
		if (eng_rvalid_o === 1'h1)
		begin
			e_exp = eng_q.pop_front();
			`CHK(eng_rdata_o, e_exp)
		end
	end

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		fail_count++;
		conclude();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{reset_i, eng_req_i, eng_we_i, eng_addr_i, eng_wdata_i} = {1'h1, 2'h0, 13'h0000, 64'h0};
		{eng_done_i, eng_done_type_i, eng_done_idx_i, done_clr_i, done_clr_type_i, done_clr_idx_i} = 16'h0;
		{irq_or_mask_i, irq_and_mask_i, pd_off_i} = 7'h00;
		seed = 16'h0056;
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
		`CHK(pulldown_en_o, 3'h7)
		`CHK(root_conn_o, 1'h0)
		`CHK(done_o, 96'h0)
		reset_i = 1'h0;
		repeat (2) @(negedge mclk_i);
		`CHK(root_conn_o, 1'h1)
		`CHK(clk_src_port_o, 2'h2)
		`CHK(port2_clk_en_o, 1'h1)
		i_cpu.enumerate_hub();
		`CHK(hub_ports_o, 2'h3)
		`CHK(route_hub_o, 3'h7)
		pd_off_i = 1'h1;
		@(negedge mclk_i);
		pd_off_i = 1'h0;
		`CHK(pulldown_en_o, 3'h0)
		$display("test hub and clocks done");
		// Region boundaries and descriptor slot fields
		for (int k = 0; k < 8; k++)
		begin
			wr(dec_a[k], {16'h0000, dec_a[k]});
			`CHK(cpu_region_o, dec_r[k])
			`CHK(cpu_td_index_o, dec_a[k][9:5])
			`CHK(cpu_td_dword_o, dec_a[k][4:2])
			if (k == 0)
			begin
				`CHK(cpu_reg_sel_o, 1'h1)
			end
		end
		for (int k = 1; k < 8; k++)
			rd(dec_a[k]);
		// Random buffer traffic, one idle cycle between accesses
		for (int k = 0; k < 8; k++)
		begin
			seed = lfsr(seed);
			a = {seed[15:2], 2'h0};
			if (a < 16'h0400)
				a[12] = 1'h1;
			seed = lfsr(seed);
			wr(a, {seed, ~seed});
			addr_q.push_back(a);
		end
		foreach (addr_q[k])
			rd(addr_q[k]);
		wr(16'h2006, 32'hA5A5_0F0F);
		`CHK(cpu_align_err_o, 1'h1)
		rd(16'h2004); // low address bits dropped
		$display("test processor map done");
		// Engine port, alone and against the processor
		wr(16'h1008, 32'h1111_2222);
		wr(16'h100C, 32'h3333_4444);
		i_cpu.release_bus();
		eng_acc(1'h0, 13'h0181, 64'h0);
		eng_acc(1'h1, 13'h1F7F, {seed, ~seed, seed, seed});
		rd(16'hFFF8);
		rd(16'hFFFC);
		fork
			wr(16'h3000, 32'hC0DE_0001);
			eng_acc(1'h1, 13'h0200, 64'h0123_4567_89AB_CDEF);
		join
		fork
			rd(16'h3000);
			eng_acc(1'h0, 13'h0200, 64'h0);
		join
		rd(16'h1400);
		rd(16'h1404);
		i_cpu.release_bus();
		$display("test engine sharing done");
		// Completion flags and both mask kinds
		irq_or_mask_i = 3'h2;
		for (int t = 0; t < 4; t++)
		begin
			flag(1'h1, td_type_t'(t), td_index_t'(4 + t));
			`CHK(irq_o, 1'(t > 0))
		end
		exp_done = 96'h0;
		exp_done[4] = 1'h1;
		exp_done[37] = 1'h1;
		exp_done[70] = 1'h1;
		`CHK(done_o, exp_done)
		irq_or_mask_i = 3'h0;
		irq_and_mask_i = 3'h7;
		@(negedge mclk_i);
		`CHK(irq_o, 1'h1)
		flag(1'h0, 2'h2, 5'h06);
		exp_done[70] = 1'h0;
		`CHK(done_o, exp_done)
		`CHK(irq_o, 1'h0)
		$display("test completion flags done");
		repeat (4) @(negedge mclk_i);
		conclude();
	end
endmodule // tb_host_buffer_memory_map

`default_nettype wire
